// File: core/ncq_abort_pkg.sv
package ncq_abort_pkg;
  // feature field layout
  localparam int SUBCMD_LSB = 0;
  localparam int SUBCMD_W = 4;
  localparam int ABORT_TYPE_LSB = 4;
  localparam int ABORT_TYPE_W = 4;
  // tag position inside sector count / sector number
  localparam int TAG_LSB = 3;
  localparam int TAG_W = 5;
  localparam logic [3:0] SUBCMD_ABORT = 4'h0;
  localparam logic [3:0] ABORT_ALL = 4'h0;
  localparam logic [3:0] ABORT_STREAMING = 4'h1;
  localparam logic [3:0] ABORT_NON_STREAMING = 4'h2;
  localparam logic [3:0] ABORT_SELECTED = 4'h3;
  // one bit per abort type 0..3, as reported in the queue management log
  localparam logic [15:0] SUPPORTED_TYPES_RESET = 16'h000F;
  localparam int QUEUE_DEPTH = 32;
endpackage : ncq_abort_pkg

// File: core/ncq_abort_subcommand_decoder.sv
`timescale 1ns/1ns
// What this block does
// - feature bits 3:0 equal to 0h select the abort subcommand
// - feature bits 7:4 carry the abort type code
// - supported abort types are reported for the queue management log page
// - sector number bits 7:3 carry the target queue slot
// - target slot used only for abort type 3h, ignored otherwise
// - type 0h cancels every outstanding queued command except the abort's own tag
// - type 1h cancels only streaming commands
// - type 2h cancels only non-streaming commands
// - type 3h cancels only the command whose tag matches the target slot
// - reject when queuing off, target equals own tag, target invalid, type unsupported
// - supported type succeeds even when nothing is cancelled
// - success sends one completion covering abort tag and cancelled commands
module ncq_abort_subcommand_decoder
  import ncq_abort_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // command parameters
  input wire logic cmd_valid_in,
  input wire logic [7:0] feature_in,
  input wire logic [7:0] sector_count_in,
  input wire logic [7:0] sector_number_in,
  // device state
  input wire logic queuing_enabled_in,
  input wire logic [DEPTH-1:0] outstanding_in,
  input wire logic [DEPTH-1:0] streaming_in,
  input wire logic [15:0] supported_types_in,
  // results
  output logic done_out,
  output logic aborted_err_out,
  output logic [DEPTH-1:0] cancel_out,
  output logic [DEPTH-1:0] complete_out,
  output logic [15:0] supported_log_out
);

  // tags are five bits wide, so no more than 32 slots can ever be named
  if (DEPTH < 1 || DEPTH > (1 << TAG_W))
  begin : g_depth_check
    $error("DEPTH must be 1..32");
  end

  logic done_r, done_nxt;
  logic err_r, err_nxt;
  logic [DEPTH-1:0] cancel_r, cancel_nxt;
  logic [DEPTH-1:0] complete_r, complete_nxt;
  logic [15:0] log_r, log_nxt;

  logic [SUBCMD_W-1:0] subcmd;
  logic [ABORT_TYPE_W-1:0] abort_type;
  logic [TAG_W-1:0] own_tag;
  logic [TAG_W-1:0] target_queue_slot;
  logic is_abort;
  logic type_ok;
  logic slot_bad;
  logic [DEPTH-1:0] own_bit;
  logic [DEPTH-1:0] victims;

  assign subcmd = feature_in[SUBCMD_LSB +: SUBCMD_W];
  assign abort_type = feature_in[ABORT_TYPE_LSB +: ABORT_TYPE_W];
  // tags come from the upper field only, the low bits are don't-care
  assign own_tag = sector_count_in[TAG_LSB +: TAG_W];
  assign target_queue_slot = sector_number_in[TAG_LSB +: TAG_W];
  assign is_abort = cmd_valid_in && (subcmd == SUBCMD_ABORT);
  assign type_ok = supported_types_in[abort_type];

  // target checks only matter when the selected type uses the slot
  always_comb
  begin
    slot_bad = 1'b0;
    if (abort_type == ABORT_SELECTED)
      slot_bad = (target_queue_slot == own_tag)
        || (32'(target_queue_slot) >= DEPTH);
  end

  generate
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_slot
      // per-slot compare keeps an own tag beyond DEPTH from indexing out of range
      assign own_bit[i] = (own_tag == TAG_W'(i));
      always_comb
      begin
        victims[i] = 1'b0;
        case (abort_type)
          ABORT_ALL: victims[i] = outstanding_in[i];
          ABORT_STREAMING: victims[i] = outstanding_in[i] && streaming_in[i];
          ABORT_NON_STREAMING: victims[i] = outstanding_in[i] && !streaming_in[i];
          ABORT_SELECTED: victims[i] = outstanding_in[i]
            && (target_queue_slot == TAG_W'(i));
          default: victims[i] = 1'b0;
        endcase
        // the abort command itself is never its own victim
        if (own_bit[i])
          victims[i] = 1'b0;
      end
    end
  endgenerate

  always_comb
  begin
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    cancel_nxt = '0;
    complete_nxt = '0;
    log_nxt = supported_types_in;
    if (is_abort)
    begin
      done_nxt = 1'b1;
      if (!queuing_enabled_in || !type_ok || slot_bad)
        err_nxt = 1'b1;
      else
      begin
        // success even with an empty victim set
        cancel_nxt = victims;
        complete_nxt = victims | own_bit;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      done_r <= 1'b0;
      err_r <= 1'b0;
      cancel_r <= '0;
      complete_r <= '0;
      log_r <= SUPPORTED_TYPES_RESET;
    end
    else
    begin
      done_r <= done_nxt;
      err_r <= err_nxt;
      cancel_r <= cancel_nxt;
      complete_r <= complete_nxt;
      log_r <= log_nxt;
    end
  end

  assign done_out = done_r;
  assign aborted_err_out = err_r;
  assign cancel_out = cancel_r;
  assign complete_out = complete_r;
  assign supported_log_out = log_r;

  property p_err_no_cancel;
    @(posedge clk_in) disable iff (reset_in)
    aborted_err_out |-> (cancel_out == '0) && (complete_out == '0) && done_out;
  endproperty
  a_err_no_cancel: assert property (p_err_no_cancel) else $error("error with cancels");

  property p_off_rejects;
    @(posedge clk_in) disable iff (reset_in)
    (is_abort && !queuing_enabled_in) |=> aborted_err_out;
  endproperty
  a_off_rejects: assert property (p_off_rejects) else $error("queuing off not rejected");

  property p_success;
    @(posedge clk_in) disable iff (reset_in)
    (is_abort && queuing_enabled_in && type_ok && abort_type != ABORT_SELECTED)
      |=> done_out && !aborted_err_out;
  endproperty
  a_success: assert property (p_success) else $error("supported type failed");

  property p_complete_own;
    @(posedge clk_in) disable iff (reset_in)
    (done_out && !aborted_err_out) |-> ((complete_out & ~cancel_out) != '0);
  endproperty
  a_complete_own: assert property (p_complete_own) else $error("own tag not completed");

  property p_streaming_only;
    @(posedge clk_in) disable iff (reset_in)
    (is_abort && abort_type == ABORT_STREAMING) |=> ((cancel_out & ~$past(streaming_in)) == '0);
  endproperty
  a_streaming_only: assert property (p_streaming_only) else $error("non-streaming cancelled");

  property p_nonstreaming_only;
    @(posedge clk_in) disable iff (reset_in)
    (is_abort && abort_type == ABORT_NON_STREAMING) |=> ((cancel_out & $past(streaming_in)) == '0);
  endproperty
  a_nonstreaming_only: assert property (p_nonstreaming_only) else $error("streaming cancelled");

  property p_cancel_outstanding;
    @(posedge clk_in) disable iff (reset_in)
    done_out |-> ((cancel_out & ~$past(outstanding_in)) == '0);
  endproperty
  a_cancel_outstanding: assert property (p_cancel_outstanding) else $error("idle slot cancelled");

  property p_idle_quiet;
    @(posedge clk_in) disable iff (reset_in)
    !(cmd_valid_in && subcmd == SUBCMD_ABORT) |=> !done_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("done without abort");

  property p_selected_single;
    @(posedge clk_in) disable iff (reset_in)
    (is_abort && abort_type == ABORT_SELECTED) |=> $onehot0(cancel_out);
  endproperty
  a_selected_single: assert property (p_selected_single) else $error("selected hit many");

  property p_unsupported_rejects;
    @(posedge clk_in) disable iff (reset_in)
    (is_abort && !type_ok) |=> (done_out && aborted_err_out);
  endproperty
  a_unsupported_rejects: assert property (p_unsupported_rejects) else $error("bad type taken");

  property p_self_target_rejects;
    @(posedge clk_in) disable iff (reset_in)
    (is_abort && abort_type == ABORT_SELECTED && target_queue_slot == own_tag) |=> aborted_err_out;
  endproperty
  a_self_target_rejects: assert property (p_self_target_rejects) else $error("self slot taken");

  property p_slot_range_rejects;
    @(posedge clk_in) disable iff (reset_in)
    (is_abort && abort_type == ABORT_SELECTED && 32'(target_queue_slot) >= DEPTH) |=> aborted_err_out;
  endproperty
  a_slot_range_rejects: assert property (p_slot_range_rejects) else $error("bad slot taken");

endmodule : ncq_abort_subcommand_decoder

// File: testbench/host_cmd_model.sv
`timescale 1ns/1ns
module host_cmd_model
(
  // clock
  input wire logic clk_in,
  // command fields
  output logic cmd_valid_out,
  output logic [7:0] feature_out,
  output logic [7:0] count_out,
  output logic [7:0] number_out
);
  initial
  begin
    cmd_valid_out = 1'b0;
    feature_out = 8'h00;
    count_out = 8'h00;
    number_out = 8'h00;
  end
  // fields are inverted once released so stale values never look valid
  task automatic send(input logic [7:0] f, input logic [4:0] t, input logic [4:0] s,
    input logic [2:0] l);
    @(posedge clk_in);
    #10;
    cmd_valid_out = 1'b1;
    feature_out = f;
    count_out = {t, l};
    number_out = {s, ~l};
    @(posedge clk_in);
    #10;
    cmd_valid_out = 1'b0;
    feature_out = ~f;
    count_out = ~count_out;
    number_out = ~number_out;
  endtask : send
endmodule : host_cmd_model

// File: testbench/ncq_abort_subcommand_decoder_tb_top.sv
`timescale 1ns/1ns
module ncq_abort_subcommand_decoder_tb_top;
  import ncq_abort_pkg::*;
  localparam int D = 8;
  logic clk, rst, vld, q_en, done, err;
  logic [7:0] feat, cnt, num, outs, strm, canc, comp;
  logic [15:0] sup, log_v;
  int failures = 0;
  int samples_checked = 0;
  host_cmd_model u_host (.clk_in(clk), .cmd_valid_out(vld), .feature_out(feat),
    .count_out(cnt), .number_out(num));
  ncq_abort_subcommand_decoder #(.DEPTH(D)) u_dut (.clk_in(clk), .reset_in(rst),
    .cmd_valid_in(vld), .feature_in(feat), .sector_count_in(cnt), .sector_number_in(num),
    .queuing_enabled_in(q_en), .outstanding_in(outs), .streaming_in(strm),
    .supported_types_in(sup), .done_out(done), .aborted_err_out(err), .cancel_out(canc),
    .complete_out(comp), .supported_log_out(log_v));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic run(input logic [7:0] f, input logic [4:0] t, input logic [4:0] s,
    input logic [2:0] l, input logic e, input logic [7:0] c);
    u_host.send(f, t, s, l);
    chk("done", 16'h0001, {15'h0, done});
    chk("err", {15'h0, e}, {15'h0, err});
    chk("cancel", {8'h00, c}, {8'h00, canc});
    chk("complete", e ? 16'h0000 : {8'h00, c | (8'h01 << t)}, {8'h00, comp});
    @(posedge clk);
    #10;
    chk("done_low", 16'h0000, {15'h0, done});
  endtask : run
  task automatic check_types;
    run(8'h00, 5'd1, 5'd1, 3'h7, 1'b0, 8'hF4);
    run(8'h10, 5'd0, 5'd0, 3'h0, 1'b0, 8'h34);
    run(8'h20, 5'd0, 5'd0, 3'h0, 1'b0, 8'hC2);
    run(8'h30, 5'd0, 5'd2, 3'h5, 1'b0, 8'h04);
    run(8'h30, 5'd0, 5'd3, 3'h0, 1'b0, 8'h00);
  endtask : check_types
  task automatic check_refusals;
    run(8'h30, 5'd1, 5'd1, 3'h0, 1'b1, 8'h00);
    run(8'h30, 5'd1, 5'd9, 3'h0, 1'b1, 8'h00);
    run(8'h40, 5'd1, 5'd0, 3'h0, 1'b1, 8'h00);
    sup = 16'h000B;
    run(8'h20, 5'd1, 5'd0, 3'h0, 1'b1, 8'h00);
    sup = 16'h000F;
    q_en = 1'b0;
    run(8'h00, 5'd1, 5'd0, 3'h0, 1'b1, 8'h00);
    q_en = 1'b1;
  endtask : check_refusals
  task automatic check_other;
    u_host.send(8'h01, 5'd0, 5'd2, 3'h0);
    chk("done_other", 16'h0000, {15'h0, done});
    sup = 16'h0005;
    @(posedge clk);
    #10;
    chk("log", 16'h0005, log_v);
    sup = 16'h000F;
  endtask : check_other
  // reset lands while a result pulse stands; the log must fall back to its reset value
  task automatic check_reset_mid;
    sup = 16'h0005;
    u_host.send(8'h00, 5'd0, 5'd0, 3'h0);
    chk("done_before", 16'h0001, {15'h0, done});
    rst = 1'b1;
    #10;
    chk("done_async", 16'h0000, {15'h0, done});
    chk("cancel_async", 16'h0000, {8'h00, canc});
    chk("log_async", 16'h000F, log_v);
    @(posedge clk);
    #10;
    rst = 1'b0;
    @(posedge clk);
    #10;
    chk("log_after", 16'h0005, log_v);
    chk("done_after", 16'h0000, {15'h0, done});
    sup = 16'h000F;
  endtask : check_reset_mid
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    q_en = 1'b1;
    outs = 8'hF6;
    strm = 8'h3C;
    sup = 16'h000F;
    repeat (6) @(posedge clk);
    chk("log_reset", 16'h000F, log_v);
    chk("done_reset", 16'h0000, {15'h0, done});
    #10;
    rst = 1'b0;
    check_types();
    check_refusals();
    check_other();
    check_reset_mid();
    check_types();
    tally_and_finish();
  end
endmodule : ncq_abort_subcommand_decoder_tb_top
